/* File: dpra_pkg.sv */
// shared constants and types for the dual pot register bank
package dpra_pkg;
   // address byte codes, low three bits
   localparam logic [2:0] ADDR_WIPER_0A = 3'h0;
   localparam logic [2:0] ADDR_WIPER_1B = 3'h1;
   localparam logic [2:0] ADDR_WIPER_1A = 3'h2;
   localparam logic [2:0] ADDR_WIPER_0B = 3'h3;
   localparam logic [2:0] ADDR_LEVEL = 3'h7;
   // level select register fields and reset value
   localparam logic [7:0] LEVEL_RESET = 8'h00;
   localparam int LEVEL_NV_BIT = 0;
   localparam int LEVEL_CODE_LOW = 1;
   localparam int LEVEL_CODE_HIGH = 2;
   localparam int LEVEL_CTRL_BITS = 3;
   // organisation
   localparam int NUM_WIPERS = 4;
   localparam int NUM_LEVELS = 4;
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
   // slave address byte fields
   localparam int SA_TYPE_LSB = 4;
   localparam int SA_HW_LSB = 1;
   localparam int SA_DIR_BIT = 0;
   // arbitrary device type value, not a real identifier
   localparam logic [3:0] DEV_TYPE_DEFAULT = 4'hA;
   // nonvolatile programming time
   localparam int NV_PROG_TIME_US = 5000;
   localparam int CLK_MHZ = 250;
   localparam int NV_PROG_CYCLES = NV_PROG_TIME_US * CLK_MHZ;

   typedef struct packed {
      logic scl;
      logic sda;
      logic hw_addr_pin_2;
      logic hw_addr_pin_1;
      logic hw_addr_pin_0;
      logic write_protect_n;
   } dpra_pins_t;

   typedef logic [NUM_WIPERS-1:0][BYTE_BITS-1:0] dpra_wiper_set_t;
   typedef logic [NUM_WIPERS*NUM_LEVELS-1:0][BYTE_BITS-1:0] dpra_store_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_ACKOUT = 3'b010,
      ST_TX = 3'b011,
      ST_ACKIN = 3'b100
   } dpra_state_t;

   typedef enum logic [1:0] {
      PH_DEVSEL = 2'b00,
      PH_WORD = 2'b01,
      PH_DATA = 2'b10
   } dpra_phase_t;
endpackage : dpra_pkg

/* File: dpra_pin_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module dpra_pin_sync #(
   parameter int W = 6,
   parameter logic [W-1:0] RESET_VAL = '1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // pins in, filtered levels out
   input wire logic [W-1:0] pin_async,
   output logic [W-1:0] pin_stable
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } dpra_sync_state_t;

   dpra_sync_state_t s_reg;
   dpra_sync_state_t s_next;

   if (W < 1) begin : g_chk
      $error("pin sync width must be at least one");
   end

   always_comb begin
      s_next = s_reg;
      s_next.s1 = pin_async;
      s_next.s2 = s_reg.s1;
      s_next.s3 = s_reg.s2;
      // a level only counts once the second and third stage agree
      s_next.q = (s_reg.s2 & s_reg.s3) | (s_reg.q & (s_reg.s2 | s_reg.s3));
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
      end else begin
         s_reg <= s_next;
      end
   end

   assign pin_stable = s_reg.q;
endmodule : dpra_pin_sync

/* File: dpra_prog_timer.sv */
// busy timer for the nonvolatile programming cycle
`timescale 1ns/1ps
module dpra_prog_timer #(
   parameter int CYCLES = dpra_pkg::NV_PROG_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // start pulse and busy level
   input wire logic start,
   output logic busy
);
   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic busy;
   } dpra_timer_state_t;

   dpra_timer_state_t s_reg;
   dpra_timer_state_t s_next;

   if (CYCLES < 1) begin : g_chk
      $error("programming time must be at least one cycle");
   end

   always_comb begin
      s_next = s_reg;
      if (start && !s_reg.busy) begin
         s_next.busy = 1'b1;
         s_next.cnt = CW'(CYCLES - 1);
      end else if (s_reg.busy) begin
         if (s_reg.cnt == '0) begin
            s_next.busy = 1'b0;
         end else begin
            s_next.cnt = s_reg.cnt - CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign busy = s_reg.busy;
endmodule : dpra_prog_timer

/* File: dpra_regs.sv */
// two-wire slave holding the wiper and stored setting registers
`timescale 1ns/1ps
module dpra_regs #(
   parameter logic [3:0] DEV_TYPE = dpra_pkg::DEV_TYPE_DEFAULT,
   parameter int PROG_CYCLES = dpra_pkg::NV_PROG_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // straps and write protect
   input wire logic hw_addr_pin_2,
   input wire logic hw_addr_pin_1,
   input wire logic hw_addr_pin_0,
   input wire logic write_protect_n,
   // wiper positions and status
   output dpra_pkg::dpra_wiper_set_t wiper_pos,
   output logic [7:0] level_select,
   output logic prog_busy
);
   typedef struct packed {
      dpra_pkg::dpra_state_t st;
      dpra_pkg::dpra_phase_t ph;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic mack;
      logic [2:0] sel;
      logic [1:0] ptr;
      logic [2:0] lsel;
      dpra_pkg::dpra_wiper_set_t wiper;
      dpra_pkg::dpra_wiper_set_t stage;
      logic [3:0] mask;
      logic nv_pend;
      dpra_pkg::dpra_store_t nv;
      logic oe;
      logic sda_lvl;
      logic scl_q;
      logic sda_q;
   } dpra_core_t;

   dpra_core_t s_reg;
   dpra_core_t s_next;
   dpra_pkg::dpra_pins_t pins_raw;
   dpra_pkg::dpra_pins_t pins;
   logic rise;
   logic fall;
   logic start_c;
   logic stop_c;
   logic ev_lvl;
   logic ev_wcr;
   logic ev_dr;
   logic ev_commit;
   logic ev_discard;
   logic ev_read;
   logic [31:0] ptr_mask;
   dpra_pkg::dpra_wiper_set_t row_new;

   if (PROG_CYCLES < 1) begin : g_chk
      $error("programming time must be at least one cycle");
   end

   // one stored row as seen by the four wipers
   function automatic dpra_pkg::dpra_wiper_set_t row_of(dpra_pkg::dpra_store_t nv, logic [1:0] lvl);
      dpra_pkg::dpra_wiper_set_t r;
      for (int i = 0; i < dpra_pkg::NUM_WIPERS; i++) begin
         r[i] = nv[{lvl, 2'(i)}];
      end
      return r;
   endfunction : row_of

   // load the byte to send; stored reads move the row into the wipers
   function automatic dpra_core_t do_read(dpra_core_t c);
      dpra_core_t r;
      r = c;
      if (c.sel == dpra_pkg::ADDR_LEVEL) begin
         r.sh = {5'h00, c.lsel};
      end else if (c.sel[2]) begin
         r.sh = 8'h00;
      end else if (!c.lsel[dpra_pkg::LEVEL_NV_BIT]) begin
         r.sh = c.wiper[c.ptr];
      end else begin
         r.sh = c.nv[{c.lsel[2:1], c.ptr}];
         r.wiper = row_of(c.nv, c.lsel[2:1]);
      end
      return r;
   endfunction : do_read

   assign pins_raw = '{scl: scl_in, sda: sda_in, hw_addr_pin_2: hw_addr_pin_2,
                       hw_addr_pin_1: hw_addr_pin_1, hw_addr_pin_0: hw_addr_pin_0,
                       write_protect_n: write_protect_n};

   // straps and protect pin go through the same filter as the bus lines
   dpra_pin_sync #(
      .W($bits(dpra_pkg::dpra_pins_t)),
      .RESET_VAL('1)
   ) u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .pin_async(pins_raw),
      .pin_stable(pins)
   );

   // a stop with pending stored bytes opens the busy window only while write_protect_n is high
   dpra_prog_timer #(
      .CYCLES(PROG_CYCLES)
   ) u_timer (
      .clk_sys(clk_sys),
      .srst(srst),
      .start(ev_commit),
      .busy(prog_busy)
   );

   always_comb begin
      s_next = s_reg;
      s_next.scl_q = pins.scl;
      s_next.sda_q = pins.sda;
      s_next.sda_lvl = 1'b0;
      rise = pins.scl & ~s_reg.scl_q;
      fall = ~pins.scl & s_reg.scl_q;
      start_c = s_reg.scl_q & pins.scl & s_reg.sda_q & ~pins.sda;
      stop_c = s_reg.scl_q & pins.scl & ~s_reg.sda_q & pins.sda;
      ev_lvl = 1'b0;
      ev_wcr = 1'b0;
      ev_dr = 1'b0;
      ev_commit = 1'b0;
      ev_discard = 1'b0;
      ev_read = 1'b0;
      ptr_mask = 32'hFF << {s_reg.ptr, 3'h0};
      row_new = row_of(s_reg.nv, s_reg.sh[2:1]);
      if (prog_busy) begin
         // bus ignored and released while programming
         s_next.st = dpra_pkg::ST_IDLE;
         s_next.oe = 1'b0;
      end else if (start_c) begin
         // repeated start keeps the pointer for a random read
         s_next.st = dpra_pkg::ST_RX;
         s_next.ph = dpra_pkg::PH_DEVSEL;
         s_next.cnt = 4'h0;
         s_next.oe = 1'b0;
      end else if (stop_c) begin
         s_next.st = dpra_pkg::ST_IDLE;
         s_next.oe = 1'b0;
         if (s_reg.nv_pend && pins.write_protect_n) begin
            ev_commit = 1'b1;
            for (int i = 0; i < dpra_pkg::NUM_WIPERS; i++) begin
               if (s_reg.mask[i]) begin
                  s_next.nv[{s_reg.lsel[2:1], 2'(i)}] = s_reg.stage[i];
               end
            end
         end else if (s_reg.nv_pend) begin
            ev_discard = 1'b1;
         end
         s_next.nv_pend = 1'b0;
         s_next.mask = 4'h0;
      end else begin
         unique case (s_reg.st)
            dpra_pkg::ST_IDLE: begin
            end
            dpra_pkg::ST_RX: begin
               if (rise && s_reg.cnt != dpra_pkg::BIT_COUNT_FULL) begin
                  s_next.sh = {s_reg.sh[6:0], pins.sda};
                  s_next.cnt = s_reg.cnt + 4'h1;
               end else if (fall && s_reg.cnt == dpra_pkg::BIT_COUNT_FULL) begin
                  s_next.oe = 1'b1;
                  s_next.st = dpra_pkg::ST_ACKOUT;
                  unique case (s_reg.ph)
                     dpra_pkg::PH_DEVSEL: begin
                        // type in 7:4, straps in 3:1, direction in bit 0
                        if (s_reg.sh[7:dpra_pkg::SA_TYPE_LSB] != DEV_TYPE ||
                            s_reg.sh[3:dpra_pkg::SA_HW_LSB] !=
                            {pins.hw_addr_pin_2, pins.hw_addr_pin_1, pins.hw_addr_pin_0}) begin
                           s_next.oe = 1'b0;
                           s_next.st = dpra_pkg::ST_IDLE;
                        end
                        s_next.rw = s_reg.sh[dpra_pkg::SA_DIR_BIT];
                     end
                     dpra_pkg::PH_WORD: begin
                        // upper bits are not decoded
                        s_next.sel = s_reg.sh[2:0];
                        s_next.ptr = s_reg.sh[1:0];
                     end
                     default: begin
                        if (s_reg.sel == dpra_pkg::ADDR_LEVEL) begin
                           ev_lvl = 1'b1;
                           s_next.lsel = s_reg.sh[2:0];
                           if (s_reg.sh[dpra_pkg::LEVEL_NV_BIT]) begin
                              s_next.wiper = row_new;
                           end
                        end else if (s_reg.sel[2]) begin
                           // unused codes take the byte and drop it
                        end else if (!s_reg.lsel[dpra_pkg::LEVEL_NV_BIT]) begin
                           ev_wcr = 1'b1;
                           s_next.wiper[s_reg.ptr] = s_reg.sh;
                           s_next.ptr = s_reg.ptr + 2'h1;
                        end else begin
                           ev_dr = 1'b1;
                           s_next.stage[s_reg.ptr] = s_reg.sh;
                           s_next.mask[s_reg.ptr] = 1'b1;
                           s_next.nv_pend = 1'b1;
                           s_next.ptr = s_reg.ptr + 2'h1;
                           for (int i = 0; i < dpra_pkg::NUM_WIPERS; i++) begin
                              // written wipers show the new byte, the rest their stored row
                              s_next.wiper[i] = s_next.mask[i] ? s_next.stage[i] :
                                                s_reg.nv[{s_reg.lsel[2:1], 2'(i)}];
                           end
                        end
                     end
                  endcase
               end
            end
            dpra_pkg::ST_ACKOUT: begin
               if (fall) begin
                  s_next.oe = 1'b0;
                  s_next.cnt = 4'h0;
                  if (s_reg.ph == dpra_pkg::PH_DEVSEL && s_reg.rw) begin
                     ev_read = 1'b1;
                     s_next = do_read(s_next);
                     s_next.st = dpra_pkg::ST_TX;
                     s_next.oe = ~s_next.sh[7];
                  end else begin
                     s_next.st = dpra_pkg::ST_RX;
                     s_next.ph = (s_reg.ph == dpra_pkg::PH_DEVSEL) ? dpra_pkg::PH_WORD : dpra_pkg::PH_DATA;
                  end
               end
            end
            dpra_pkg::ST_TX: begin
               if (rise) begin
                  s_next.cnt = s_reg.cnt + 4'h1;
               end else if (fall) begin
                  if (s_reg.cnt == dpra_pkg::BIT_COUNT_FULL) begin
                     s_next.oe = 1'b0;
                     s_next.st = dpra_pkg::ST_ACKIN;
                  end else begin
                     s_next.sh = {s_reg.sh[6:0], 1'b0};
                     s_next.oe = ~s_reg.sh[6];
                  end
               end
            end
            dpra_pkg::ST_ACKIN: begin
               if (rise) begin
                  s_next.mack = ~pins.sda;
               end else if (fall) begin
                  if (s_reg.mack) begin
                     ev_read = 1'b1;
                     s_next.ptr = s_reg.ptr + 2'h1;
                     s_next = do_read(s_next);
                     s_next.cnt = 4'h0;
                     s_next.st = dpra_pkg::ST_TX;
                     s_next.oe = ~s_next.sh[7];
                  end else begin
                     s_next.st = dpra_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               s_next.st = dpra_pkg::ST_IDLE;
               s_next.oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s_reg <= '0;
         s_reg.lsel <= dpra_pkg::LEVEL_RESET[2:0];
         // edge history starts at the idle bus level, so release shows no false edge
         s_reg.scl_q <= 1'b1;
         s_reg.sda_q <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wiper_pos = s_reg.wiper;
   assign level_select = {5'h00, s_reg.lsel};
   assign sda_oe = s_reg.oe;
   assign sda_out = s_reg.sda_lvl;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   a_odd_level_copy: assert property (ev_lvl && s_reg.sh[0] |=> s_reg.wiper == $past(row_new))
      else $error("odd level write did not copy stored row");
   a_even_level_keep: assert property (ev_lvl && !s_reg.sh[0] |=> $stable(s_reg.wiper))
      else $error("even level write changed a wiper");
   a_wcr_only_one: assert property (ev_wcr |=>
      ((s_reg.wiper ^ $past(s_reg.wiper)) & ~$past(ptr_mask)) == '0)
      else $error("volatile write touched another wiper");
   a_dr_loads_wiper: assert property (ev_dr |=> s_reg.wiper[$past(s_reg.ptr)] == $past(s_reg.sh))
      else $error("stored write did not load its wiper");
   a_page_wrap: assert property ((ev_wcr || ev_dr) |=> s_reg.ptr == $past(s_reg.ptr) + 2'h1)
      else $error("page pointer did not advance");
   a_nv_prog_start: assert property (ev_commit |=> prog_busy ##1 prog_busy)
      else $error("programming did not start after stored write stop");
   a_wp_discard: assert property (ev_discard && !prog_busy |=>
      !prog_busy && s_reg.nv == $past(s_reg.nv))
      else $error("protected stored write was not discarded");
   a_busy_no_ack: assert property (prog_busy |-> ##1 (!sda_oe && s_reg.st == dpra_pkg::ST_IDLE))
      else $error("slave answered while programming");
   a_level_reserved: assert property (ev_lvl |=> level_select == {5'h00, $past(s_reg.sh[2:0])})
      else $error("level select write did not land in the low bits");
   a_volatile_ready: assert property (stop_c && !s_reg.nv_pend && !prog_busy |=> !prog_busy)
      else $error("volatile stop made the slave busy");
   // level register reads back its control bits with the reserved bits clear
   a_level_readback: assert property (ev_read && s_reg.sel == dpra_pkg::ADDR_LEVEL |=>
      s_reg.sh == {5'h00, s_reg.lsel})
      else $error("level select read loaded the wrong byte");
   a_stop_release: assert property (stop_c && !prog_busy |=> !sda_oe)
      else $error("data line still pulled after stop");
   // master owns the line while it acknowledges a read byte
   a_ackin_release: assert property (s_reg.st == dpra_pkg::ST_ACKIN |-> !sda_oe)
      else $error("data line pulled during master acknowledge");

   c_odd_level: cover property (ev_lvl && s_reg.sh[0]);
   c_stored_page: cover property (ev_dr ##[1:1000] ev_dr);
   c_commit: cover property (ev_commit);
   c_read_burst: cover property (ev_read ##[1:1000] ev_read);
   c_protect_drop: cover property (ev_discard);
endmodule : dpra_regs

/* File: dpra_bus_master.sv */
// two-wire bus master model for the pot register bench
`timescale 1ns/1ps
module dpra_bus_master (
   // clock
   input wire logic clk_sys,
   // bus lines, data is open drain
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   // clock stands high between frames, data released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // quarter bus period; keeps data edges clear of clock edges
   task automatic qtr();
      repeat (10) @(posedge clk_sys);
   endtask : qtr
   // data moves only while the clock is low, sampled mid-high
   task automatic bit_io(input logic b, output logic s);
      qtr();
      sda_low <= ~b;
      qtr();
      scl <= 1'b1;
      qtr();
      s = sda;
      qtr();
      scl <= 1'b0;
   endtask : bit_io
   // start, or repeated start from a low clock
   task automatic start();
      qtr();
      if (!scl) begin
         sda_low <= 1'b0;
         qtr();
         scl <= 1'b1;
         qtr();
      end
      sda_low <= 1'b1;
      qtr();
      scl <= 1'b0;
   endtask : start
   task automatic stop();
      qtr();
      sda_low <= 1'b1;
      qtr();
      scl <= 1'b1;
      qtr();
      sda_low <= 1'b0;
      qtr();
   endtask : stop
   // msb first, then the slave acknowledge
   task automatic send(input logic [7:0] b, output int ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, s);
      // an unknown line counts as neither answer, so every ack check trips
      ack = (s === 1'b0) ? 1 : ((s === 1'b1) ? 0 : 16);
   endtask : send
   // write command; gives up after an unanswered slave address
   task automatic wr(input logic [6:0] sa, input logic [7:0] a, input logic [4:0][7:0] d,
                     input int n, output int acks);
      int k;
      start();
      send({sa, 1'b0}, acks);
      if (acks == 1) begin
         send(a, k);
         acks += k;
         for (int i = 0; i < n; i++) begin
            send(d[i], k);
            acks += k;
         end
      end
      stop();
   endtask : wr
   // one byte read, left unacknowledged so the slave lets go
   task automatic rd(input logic [6:0] sa, input logic [7:0] a, output logic [7:0] d,
                     output int acks);
      int k;
      logic s;
      start();
      send({sa, 1'b0}, acks);
      send(a, k);
      acks += k;
      start();
      send({sa, 1'b1}, k);
      acks += k;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(1'b1, s);
      stop();
   endtask : rd
endmodule : dpra_bus_master

/* File: dpra_regs_test.sv */
// self-checking bench for the dual pot register bank
`timescale 1ns/1ps
module dpra_regs_test;
   // short programming time keeps the run small
   localparam int PROG = 1500;
   localparam int LIMIT = 90000;
   logic clk_sys;
   logic srst;
   logic scl;
   logic sda_low;
   logic sda;
   logic [2:0] hw;
   logic write_protect_n;
   logic sda_out;
   logic sda_oe;
   dpra_pkg::dpra_wiper_set_t wiper_pos;
   logic [7:0] level_select;
   logic prog_busy;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [6:0] sa;
   dpra_pkg::dpra_wiper_set_t e;
   logic [7:0] b;
   int acks;
   // pull-up on data; either side may pull it low
   assign sda = ~(sda_low | (sda_oe & ~sda_out));
   dpra_regs #(.DEV_TYPE(dpra_pkg::DEV_TYPE_DEFAULT), .PROG_CYCLES(PROG)) uut (
      .clk_sys(clk_sys), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .hw_addr_pin_2(hw[2]), .hw_addr_pin_1(hw[1]), .hw_addr_pin_0(hw[0]),
      .write_protect_n(write_protect_n), .wiper_pos(wiper_pos), .level_select(level_select),
      .prog_busy(prog_busy));
   dpra_bus_master mst (.clk_sys(clk_sys), .scl(scl), .sda_low(sda_low), .sda(sda));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic test_done();
      if (num_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         num_errors++;
         test_done();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic w(input logic [7:0] a, input logic [4:0][7:0] d, input int n);
      int k;
      mst.wr(sa, a, d, n, k);
      check("write acks", k, n + 2);
   endtask : w
   // polls until the programming cycle ends; bounded
   task automatic settle();
      int k;
      int tries;
      mst.wr(sa, 8'h00, 8'h00, 0, k);
      check("busy poll", k, 0);
      tries = 0;
      while (k == 0 && tries < 20) begin
         mst.wr(sa, 8'h00, 8'h00, 0, k);
         tries++;
      end
      check("poll done", k, 2);
      check("idle", prog_busy, 1'b0);
   endtask : settle
   task automatic t_reset();
      check("reset wipers", wiper_pos, 32'h0);
      check("reset level", level_select, 8'h00);
      check("reset busy", prog_busy, 1'b0);
      check("reset release", sda_oe, 1'b0);
      check("open drain", sda_out, 1'b0);
   endtask : t_reset
   task automatic t_volatile();
      e = '0;
      for (int i = 0; i < 4; i++) begin
         w(8'(i), 8'h10 + 8'(i), 1);
         e[i] = 8'h10 + 8'(i);
         check("single wiper", wiper_pos, e);
      end
      // five bytes from 2: wraps and the fifth overwrites
      w(8'h02, 40'hA5A4A3A2A1, 5);
      e = 32'hA2A5A4A3;
      check("page wrap", wiper_pos, e);
   endtask : t_volatile
   task automatic t_level();
      w(8'h07, 8'hFA, 1);
      check("level bits", level_select, 8'h02);
      check("even level", wiper_pos, e);
      mst.rd(sa, 8'h07, b, acks);
      check("level read", b, 8'h02);
      // unused codes answer but hold nothing
      w(8'h04, 8'h55, 1);
      check("unused write", wiper_pos, e);
      mst.rd(sa, 8'h05, b, acks);
      check("unused read", b, 8'h00);
      check("unused acks", acks, 3);
      mst.rd(sa, 8'h03, b, acks);
      check("wiper read", b, e[3]);
      check("read acks", acks, 3);
   endtask : t_level
   task automatic t_refuse();
      mst.wr({dpra_pkg::DEV_TYPE_DEFAULT ^ 4'h1, 3'h5}, 8'h00, 8'h00, 1, acks);
      check("type miss", acks, 0);
      hw <= 3'h4;
      mst.wr(sa, 8'h00, 8'h00, 1, acks);
      check("strap miss", acks, 0);
      hw <= 3'h5;
      check("wipers kept", wiper_pos, e);
   endtask : t_refuse
   task automatic t_stored();
      w(8'h07, 8'h03, 1);
      e = '0;
      check("row copy", wiper_pos, e);
      check("level nv", level_select, 8'h03);
      w(8'h02, 8'h3A, 1);
      e[2] = 8'h3A;
      check("stored write", wiper_pos, e);
      check("prog start", prog_busy, 1'b1);
      settle();
      w(8'h07, 8'h00, 1);
      w(8'h02, 8'h11, 1);
      w(8'h07, 8'h03, 1);
      check("row recall", wiper_pos, e);
      mst.rd(sa, 8'h02, b, acks);
      check("stored read", b, 8'h3A);
   endtask : t_stored
   task automatic t_protect();
      write_protect_n <= 1'b0;
      w(8'h07, 8'h05, 1);
      w(8'h00, 8'h77, 1);
      check("no prog", prog_busy, 1'b0);
      check("protected write", wiper_pos, 32'h77);
      // a stored read moves the untouched stored byte back into the wiper
      mst.rd(sa, 8'h00, b, acks);
      check("move read", b, 8'h00);
      check("move wiper", wiper_pos, 32'h0);
      write_protect_n <= 1'b1;
      w(8'h07, 8'h05, 1);
      check("discarded", wiper_pos, 32'h0);
   endtask : t_protect
   task automatic t_levels();
      logic [3:0][31:0] rows;
      rows = {32'hC3C2C1C0, 32'h0, 32'h003A0000, 32'h0};
      w(8'h07, 8'h07, 1);
      w(8'h00, 32'hC3C2C1C0, 4);
      settle();
      for (int c = 0; c < 4; c++) begin
         w(8'h07, {5'h00, 2'(c), 1'b1}, 1);
         check("level code", level_select, {5'h00, 2'(c), 1'b1});
         check("level row", wiper_pos, rows[c]);
      end
   endtask : t_levels
   initial begin
      srst = 1'b1;
      hw = 3'h5;
      write_protect_n = 1'b1;
      sa = {dpra_pkg::DEV_TYPE_DEFAULT, 3'h5};
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (10) @(posedge clk_sys);
      t_reset();
      t_volatile();
      t_level();
      t_refuse();
      t_stored();
      t_protect();
      t_levels();
      test_done();
   end
endmodule : dpra_regs_test
